// ===== hdl/sdo_pkg.sv
// Shared constants and types for the descriptor-driven stream DMA block.
// Assumes one clock domain and descriptors supplied by same-clock logic.

package sdo_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W     = 128;  // Input stream and request data.
	localparam int ADDR_W     = 32;   // Destination address.
	localparam int LEN_W      = 16;   // Link length in stream words.
	localparam int LOOP_W     = 16;   // Loop count field.
	localparam int FIFO_DEPTH = 32;   // Words buffered ahead of requests.
	localparam int FIFO_W     = DATA_W + 2;

	// ----------------------------------------------------------------
	// Field positions inside one buffered word
	// ----------------------------------------------------------------
	localparam int POS_EOP = DATA_W;
	localparam int POS_SOP = DATA_W + 1;

	// ----------------------------------------------------------------
	// Derived values and reset values
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] WORD_BYTES = ADDR_W'(DATA_W / 8);
	localparam logic [LOOP_W-1:0] ONE_PASS   = 16'h0001;
	localparam logic [LEN_W-1:0]  ONE_WORD   = 16'h0001;
	localparam logic [ADDR_W-1:0] ADDR_RST   = 32'h0000_0000;

	// Sequencer states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		SDO_IDLE  = 3'h0,
		SDO_FETCH = 3'h1,
		SDO_WSOP  = 3'h3,
		SDO_MOVE  = 3'h2,
		SDO_DONE  = 3'h6
	} sdo_state_t;

endpackage : sdo_pkg

// ===== hdl/sdo_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; in_ready and out_valid come from flip-flops.

`timescale 1ns/1ps

module sdo_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr;
	logic [AW-1:0] rd_ptr, next_rd_ptr;
	logic [AW:0]   count, next_count;
	logic          next_in_ready, next_out_valid;
	logic          push, pop;

	// ----------------------------------------------------------------
	// Pointer and flag update
	// ----------------------------------------------------------------
	// Flags are registered so the stream source never sees a comb path.
	always_comb begin
		push           = in_valid && in_ready;
		pop            = out_valid && out_ready;
		next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
		next_in_ready  = next_count != (AW+1)'(DEPTH);
		next_out_valid = next_count != '0;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			in_ready  <= next_in_ready;
			out_valid <= next_out_valid;
		end
	end

	// Storage has no reset; only words marked valid are ever read.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign out_data = mem[rd_ptr];

endmodule : sdo_fifo

// ===== hdl/sdo_dma.sv
// Descriptor-driven DMA that turns a packet stream into write requests.
// Assumes descriptors and the stream come from logic on the same clock.
//
// Function
// - End-on-packet ends transfer after end marker.
// - Link interrupt pulses when enabled link finishes.
// - Chain interrupt pulses after whole enabled chain.
// - Clear last flag means more links follow.
// - Loop mode repeats link loop-count times.
// - Loop mode adds increment to destination each pass.

`timescale 1ns/1ps

module sdo_dma (
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	// Control.
	input  wire logic                       start,
	output logic                            busy,
	// Descriptor supply.
	input  wire logic                       desc_valid,
	output logic                            desc_ready,
	input  wire logic [sdo_pkg::ADDR_W-1:0] desc_addr,
	input  wire logic [sdo_pkg::LEN_W-1:0]  desc_len,
	input  wire logic                       desc_sop_start,
	input  wire logic                       desc_eop_end,
	input  wire logic                       desc_link_int_en,
	input  wire logic                       desc_chain_int_en,
	input  wire logic                       desc_chain_end,
	input  wire logic                       desc_incr_mode,
	input  wire logic [sdo_pkg::LOOP_W-1:0] desc_loop_len,
	input  wire logic [sdo_pkg::ADDR_W-1:0] desc_loop_incr,
	// Input packet stream.
	input  wire logic [sdo_pkg::DATA_W-1:0] s_data,
	input  wire logic                       s_valid,
	output logic                            s_ready,
	input  wire logic                       s_sop,
	input  wire logic                       s_eop,
	// Write requests toward the endpoint.
	output logic [sdo_pkg::DATA_W-1:0]      wr_data,
	output logic [sdo_pkg::ADDR_W-1:0]      wr_addr,
	output logic                            wr_valid,
	input  wire logic                       wr_ready,
	output logic                            wr_first,
	output logic                            wr_last,
	// Event pulses.
	output logic                            link_irq,
	output logic                            chain_irq
);
	import sdo_pkg::*;

	// ----------------------------------------------------------------
	// Input buffer
	// ----------------------------------------------------------------
	logic [FIFO_W-1:0] f_out;
	logic              f_valid;
	logic              f_pop;
	logic              f_in_ready;

	sdo_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_data   ({s_sop, s_eop, s_data}),
		.in_valid  (s_valid),
		.in_ready  (f_in_ready),
		.out_data  (f_out),
		.out_valid (f_valid),
		.out_ready (f_pop)
	);

	// The buffer's ready is a flip-flop, so it leaves the block as is.
	assign s_ready = f_in_ready;

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	sdo_state_t        state, next_state;
	logic              d_sop, next_d_sop;
	logic              d_eop, next_d_eop;
	logic              d_lint, next_d_lint;
	logic              d_cint, next_d_cint;
	logic              d_cend, next_d_cend;
	logic              d_incr, next_d_incr;
	logic [LEN_W-1:0]  d_len, next_d_len;
	logic [ADDR_W-1:0] d_step, next_d_step;
	logic [ADDR_W-1:0] base, next_base;
	logic [ADDR_W-1:0] ptr, next_ptr;
	logic [LOOP_W-1:0] loops, next_loops;
	logic [LEN_W-1:0]  words, next_words;
	logic              first, next_first;
	logic              slot_free;
	logic              head_sop;
	logic              head_eop;
	logic              beat_end;

	logic              next_desc_ready, next_busy;
	logic              next_wr_valid, next_wr_first, next_wr_last;
	logic [DATA_W-1:0] next_wr_data;
	logic [ADDR_W-1:0] next_wr_addr;
	logic              next_link_irq, next_chain_irq;

	// ----------------------------------------------------------------
	// Next-value logic
	// ----------------------------------------------------------------
	// One request beat is held in an output slot; a new word is only
	// taken from the buffer when the slot is empty or being drained,
	// which is how endpoint back-pressure reaches the stream source.
	always_comb begin
		slot_free       = !wr_valid || wr_ready;
		head_sop        = f_out[POS_SOP];
		head_eop        = f_out[POS_EOP];
		beat_end        = 1'b0;
		f_pop           = 1'b0;
		next_state      = state;
		next_d_sop      = d_sop;
		next_d_eop      = d_eop;
		next_d_lint     = d_lint;
		next_d_cint     = d_cint;
		next_d_cend     = d_cend;
		next_d_incr     = d_incr;
		next_d_len      = d_len;
		next_d_step     = d_step;
		next_base       = base;
		next_ptr        = ptr;
		next_loops      = loops;
		next_words      = words;
		next_first      = first;
		next_desc_ready = 1'b0;
		next_wr_valid   = wr_ready ? 1'b0 : wr_valid;
		next_wr_data    = wr_data;
		next_wr_addr    = wr_addr;
		next_wr_first   = wr_first;
		next_wr_last    = wr_last;
		next_link_irq   = 1'b0;
		next_chain_irq  = 1'b0;
		case (state)
			SDO_IDLE: begin
				if (start) begin
					next_state      = SDO_FETCH;
					next_desc_ready = 1'b1;
				end
			end
			SDO_FETCH: begin
				next_desc_ready = !(desc_valid && desc_ready);
				if (desc_valid && desc_ready) begin
					next_d_sop  = desc_sop_start;
					next_d_eop  = desc_eop_end;
					next_d_lint = desc_link_int_en;
					next_d_cint = desc_chain_int_en;
					next_d_cend = desc_chain_end;
					next_d_incr = desc_incr_mode;
					next_d_len  = desc_len;
					next_d_step = desc_loop_incr;
					next_base   = desc_addr;
					next_ptr    = desc_addr;
					next_words  = desc_len;
					next_first  = 1'b1;
					// A zero loop count still runs the link once.
					if (desc_incr_mode && desc_loop_len != '0) begin
						next_loops = desc_loop_len;
					end else begin
						next_loops = ONE_PASS;
					end
					next_state = SDO_WSOP;
				end
			end
			SDO_WSOP: begin
				// Words ahead of a start marker are dropped rather than
				// stalled on, so a stale packet tail cannot block a link.
				if (!d_sop) begin
					next_state = SDO_MOVE;
				end else if (f_valid && head_sop) begin
					next_state = SDO_MOVE;
				end else if (f_valid) begin
					f_pop = 1'b1;
				end
			end
			SDO_MOVE: begin
				if (f_valid && slot_free) begin
					f_pop         = 1'b1;
					beat_end      = (words == ONE_WORD) ||
						(d_eop && head_eop);
					next_wr_valid = 1'b1;
					next_wr_data  = f_out[DATA_W-1:0];
					next_wr_addr  = ptr;
					next_wr_first = first;
					next_wr_last  = beat_end;
					next_first    = 1'b0;
					next_ptr      = ptr + WORD_BYTES;
					next_words    = words - ONE_WORD;
					if (beat_end) begin
						next_state = SDO_DONE;
					end
				end
			end
			SDO_DONE: begin
				// The link is only finished once its last beat has left
				// the slot, so events and the next fetch wait for it.
				if (slot_free) begin
					next_link_irq = d_lint;
					if (loops != ONE_PASS) begin
						// Another pass of the same link at the next region.
						next_loops = loops - ONE_PASS;
						next_base  = base + d_step;
						next_ptr   = base + d_step;
						next_words = d_len;
						next_first = 1'b1;
						next_state = SDO_WSOP;
					end else if (!d_cend) begin
						next_state      = SDO_FETCH;
						next_desc_ready = 1'b1;
					end else begin
						next_chain_irq = d_cint;
						next_state     = SDO_IDLE;
					end
				end
			end
			default: begin
				next_state = SDO_IDLE;
			end
		endcase
		next_busy = next_state != SDO_IDLE;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state      <= SDO_IDLE;
			d_sop      <= 1'b0;
			d_eop      <= 1'b0;
			d_lint     <= 1'b0;
			d_cint     <= 1'b0;
			d_cend     <= 1'b0;
			d_incr     <= 1'b0;
			d_len      <= '0;
			d_step     <= ADDR_RST;
			base       <= ADDR_RST;
			ptr        <= ADDR_RST;
			loops      <= '0;
			words      <= '0;
			first      <= 1'b0;
			busy       <= 1'b0;
			desc_ready <= 1'b0;
			wr_valid   <= 1'b0;
			wr_data    <= '0;
			wr_addr    <= ADDR_RST;
			wr_first   <= 1'b0;
			wr_last    <= 1'b0;
			link_irq   <= 1'b0;
			chain_irq  <= 1'b0;
		end else begin
			state      <= next_state;
			d_sop      <= next_d_sop;
			d_eop      <= next_d_eop;
			d_lint     <= next_d_lint;
			d_cint     <= next_d_cint;
			d_cend     <= next_d_cend;
			d_incr     <= next_d_incr;
			d_len      <= next_d_len;
			d_step     <= next_d_step;
			base       <= next_base;
			ptr        <= next_ptr;
			loops      <= next_loops;
			words      <= next_words;
			first      <= next_first;
			busy       <= next_busy;
			desc_ready <= next_desc_ready;
			wr_valid   <= next_wr_valid;
			wr_data    <= next_wr_data;
			wr_addr    <= next_wr_addr;
			wr_first   <= next_wr_first;
			wr_last    <= next_wr_last;
			link_irq   <= next_link_irq;
			chain_irq  <= next_chain_irq;
		end
	end

endmodule : sdo_dma

// ===== verif/sdo_dma_chk_props.sv
// Port checker for the stream DMA block.
// Assumes it is bound to every sdo_dma instance.
`timescale 1ns/1ps
module sdo_dma_chk (
	input wire logic                       clk,
	input wire logic                       arst_n,
	input wire logic                       start,
	input wire logic                       busy,
	input wire logic                       desc_valid,
	input wire logic                       desc_ready,
	input wire logic [sdo_pkg::ADDR_W-1:0] desc_addr,
	input wire logic                       desc_link_int_en,
	input wire logic                       desc_chain_int_en,
	input wire logic                       desc_chain_end,
	input wire logic                       desc_incr_mode,
	input wire logic [sdo_pkg::ADDR_W-1:0] desc_loop_incr,
	input wire logic [sdo_pkg::ADDR_W-1:0] wr_addr,
	input wire logic                       wr_valid,
	input wire logic                       wr_ready,
	input wire logic                       wr_first,
	input wire logic                       wr_last,
	input wire logic                       link_irq,
	input wire logic                       chain_irq
);
	import sdo_pkg::*;
	logic              link_en, chain_en, last_l, incr_l;
	logic [ADDR_W-1:0] base, incr_v, prev;

	// Latch the taken descriptor; the base moves on after each loop pass.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{link_en, chain_en, last_l, incr_l} <= 4'h0;
			{base, incr_v, prev} <= '0;
		end else begin
			if (desc_valid && desc_ready) begin
				{link_en, chain_en} <= {desc_link_int_en, desc_chain_int_en};
				{last_l, incr_l} <= {desc_chain_end, desc_incr_mode};
				base <= desc_addr;
				incr_v <= desc_loop_incr;
			end else if (wr_valid && wr_ready && wr_last && incr_l)
				base <= base + incr_v;
			if (wr_valid && wr_ready)
				prev <= wr_addr;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_take; desc_valid && desc_ready; endsequence
	sequence s_end; wr_valid && wr_ready && wr_last; endsequence

	a_fetch_once: assert property (s_take |=> !desc_ready)
		else $error("descriptor request stayed open");
	a_idle_no_fetch: assert property (!busy |-> !desc_ready)
		else $error("descriptor requested while idle");
	a_start_busy: assert property (start && !busy |=> busy)
		else $error("start not taken");
	a_link_irq_due: assert property (
		(s_end and link_en) |-> ##[1:4] link_irq)
		else $error("link event missing");
	a_link_irq_gate: assert property (link_irq |-> link_en)
		else $error("link event while disabled");
	a_chain_irq_gate: assert property (chain_irq |-> chain_en && last_l && !busy)
		else $error("chain event out of place");
	a_pass_base: assert property (wr_valid && wr_first |-> wr_addr == base)
		else $error("pass start address wrong");
	a_beat_step: assert property (wr_valid && !wr_first |-> wr_addr == prev + WORD_BYTES)
		else $error("beat address step wrong");
	a_next_fetch: assert property (
		(s_end and (!last_l && !incr_l)) |-> ##[1:4] desc_ready)
		else $error("next link not fetched");
endmodule : sdo_dma_chk

bind sdo_dma sdo_dma_chk u_chk (.*);

// ===== verif/sdo_ep_model.sv
// Endpoint model that accepts write beats.
// Assumes the block holds each beat until it is accepted.
`timescale 1ns/1ps
module sdo_ep_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic slow,
	output logic     wr_ready
);
	logic [1:0] cnt;

	// Slow mode accepts one cycle in four, so beats must wait held.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt      <= 2'h0;
			wr_ready <= 1'h0;
		end else begin
			cnt      <= cnt + 2'h1;
			wr_ready <= !slow || cnt == 2'h0;
		end
	end
endmodule : sdo_ep_model

// ===== verif/tb.sv
// Self-checking bench for the stream DMA block.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module tb;
	import sdo_pkg::*;
	logic              clk, arst_n, start, busy, desc_valid, desc_ready;
	logic              desc_sop_start, desc_eop_end, desc_link_int_en;
	logic              desc_chain_int_en, desc_chain_end, desc_incr_mode;
	logic              s_valid, s_ready, s_sop, s_eop, wr_valid, wr_ready;
	logic              wr_first, wr_last, link_irq, chain_irq, slow;
	logic [ADDR_W-1:0] desc_addr, desc_loop_incr, wr_addr;
	logic [LEN_W-1:0]  desc_len;
	logic [LOOP_W-1:0] desc_loop_len;
	logic [DATA_W-1:0] s_data, wr_data;
	logic [31:0]       seed, k;
	int                failures, tests_run, cycles, n_link, n_chain, ke, el;

	sdo_dma uut (.*);
	sdo_ep_model u_ep (.clk(clk), .arst_n(arst_n), .slow(slow),
		.wr_ready(wr_ready));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk(input logic [DATA_W-1:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %0h want %0h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	// One link; a corner forces start and end markers and three passes.
	task automatic link(input logic cn, li, ci, last);
		logic [31:0] a, inc, r;
		int          np, n, ln;
		a   = rnd() & 32'hffff_fff0;
		inc = rnd() & 32'h0000_fff0;
		r   = rnd() | (cn ? 32'h7f : 32'h0);
		np  = r[0] && r[6:5] != 2'h0 ? r[6:5] : 1;
		ln  = r[4:3] + 1;
		do @(negedge clk); while (!desc_ready);
		@(posedge clk);
		desc_valid <= 1'h1;
		desc_addr <= a;
		desc_loop_incr <= inc;
		{desc_sop_start, desc_eop_end, desc_incr_mode} <= r[2:0];
		desc_len <= LEN_W'(r[4:3]) + ONE_WORD;
		desc_loop_len <= LOOP_W'(r[6:5]);
		{desc_link_int_en, desc_chain_int_en, desc_chain_end} <= {li, ci, last};
		@(posedge clk);
		desc_valid <= 1'h0;
		el += li ? np : 0;
		for (int p = 0; p < np; p++) begin
			if (r[2])
				ke = (ke + 3) & ~3;
			n = r[1] && 4 - ke % 4 < ln ? 4 - ke % 4 : ln;
			for (int i = 0; i < n; i++) begin
				do @(negedge clk); while (!(wr_valid && wr_ready));
				chk(wr_data, DATA_W'(ke));
				chk(wr_addr, ADDR_W'(a + inc * p + WORD_BYTES * i));
				chk({wr_first, wr_last}, {i == 0, i == n - 1});
				ke++;
			end
		end
	endtask : link

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// Stream words carry their index; packets are four words long.
	assign s_data = DATA_W'(k);
	assign s_sop  = k[1:0] == 2'h0;
	assign s_eop  = k[1:0] == 2'h3;
	always @(posedge clk) begin
		if (s_valid && s_ready)
			k <= k + 32'h1;
		s_valid <= (s_valid && !s_ready) || rnd() > 32'h4000_0000;
	end

	// Count event pulses and cut a hung run short.
	always @(negedge clk) begin
		n_link += int'(link_irq);
		n_chain += int'(chain_irq);
		if (++cycles == 20000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		logic [31:0] r;
		int          nl;
		{arst_n, start, desc_valid, slow, s_valid} = 5'h0;
		{desc_addr, desc_loop_incr, desc_len, desc_loop_len} = 96'h0;
		{desc_sop_start, desc_eop_end, desc_incr_mode} = 3'h0;
		{desc_link_int_en, desc_chain_int_en, desc_chain_end} = 3'h0;
		seed = 32'h9;
		k = 32'h0;
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		repeat (2) @(posedge clk);
		for (int c = 0; c < 12; c++) begin
			r = rnd();
			nl = r[5:4] == 2'h0 ? 1 : r[5:4];
			slow <= r[3];
			n_link = 0;
			n_chain = 0;
			el = 0;
			start <= 1'h1;
			@(posedge clk);
			start <= 1'h0;
			for (int j = 0; j < nl; j++)
				link(c < 2 && j == 0, r[6 + j], r[9], j == nl - 1);
			do @(negedge clk); while (busy);
			@(negedge clk);
			chk(DATA_W'(n_link), DATA_W'(el));
			chk(DATA_W'(n_chain), DATA_W'(r[9]));
			chk(desc_ready, 1'h0);
			repeat (60) @(negedge clk);
			chk(s_ready, 1'h0);
		end
		complete_run();
	end
endmodule : tb
